// *** bldc_pkg.sv ***
// Constants, register map and types of the brushless motor drive control
`default_nettype none
package bldc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int DEB_TIME_US = 2000;
  localparam int DEB_CYC     = DEB_TIME_US * (CLK_HZ / 1_000_000);
  localparam int MS_CYC      = CLK_HZ / 1000;
  localparam int PWM_HZ      = 16000;
  localparam int PWM_CYC     = CLK_HZ / PWM_HZ;
  localparam int WIN_MS      = 100;
  // ==========================================================
  // Register byte addresses
  localparam logic [5:0] A_MODE  = 6'h00;
  localparam logic [5:0] A_RANGE = 6'h04;
  localparam logic [5:0] A_DYN   = 6'h08;
  localparam logic [5:0] A_SCALE = 6'h0C;
  localparam logic [5:0] A_LCOMP = 6'h10;
  localparam logic [5:0] A_SRAMP = 6'h14;
  localparam logic [5:0] A_PRAMP = 6'h18;
  localparam logic [5:0] A_ILIM  = 6'h1C;
  localparam logic [5:0] A_TDLY  = 6'h20;
  localparam logic [5:0] A_IND   = 6'h24;
  localparam logic [5:0] A_TRIP  = 6'h28;
  localparam logic [5:0] A_SPEED = 6'h2C;
  localparam logic [5:0] A_CUR   = 6'h30;
  localparam logic [5:0] A_ACC   = 6'h34;
  localparam logic [5:0] A_STAT  = 6'h38;
  // ==========================================================
  // Reset values and legal ranges
  localparam logic       MODE_RST  = 1'b0;
  localparam logic [4:0] RANGE_RST = 5'h06;
  localparam logic [4:0] RANGE_MIN = 5'h01;
  localparam logic [4:0] RANGE_MAX = 5'h12;
  localparam logic [2:0] DYN_RST   = 3'h3;
  localparam logic [2:0] DYN_MIN   = 3'h1;
  localparam logic [2:0] DYN_MAX   = 3'h5;
  localparam logic       SCALE_RST = 1'b0;
  localparam logic [5:0] LC_RST    = 6'h00;
  localparam logic [5:0] LC_MAX    = 6'h32;
  localparam logic [3:0] RAMP_RST  = 4'h4;
  localparam logic [3:0] RAMP_MAX  = 4'h8;
  localparam logic [5:0] ILIM_RST  = 6'h0F;
  localparam logic [5:0] ILIM_MAX  = 6'h3C;
  localparam logic [7:0] TDLY_RST  = 8'h28;
  localparam logic [7:0] TDLY_MAX  = 8'hC8;
  localparam logic [1:0] IND_RST   = 2'h1;
  localparam logic [4:0] CUR_MAX   = 5'h1E;
  // Ramp times in ms per code
  localparam logic [10:0] RAMP_MS [0:8] = '{11'h000, 11'h064, 11'h0C8,
    11'h12C, 11'h190, 11'h1F4, 11'h2BC, 11'h3E8, 11'h5DC};
  // ==========================================================
  // Encodings
  localparam logic [1:0] TRIP_NONE = 2'h0;
  localparam logic [1:0] TRIP_FWD  = 2'h1;
  localparam logic [1:0] TRIP_REV  = 2'h2;
  localparam logic [1:0] IND_NONE  = 2'h0;
  localparam logic [1:0] IND_TRIP  = 2'h1;
  localparam logic [1:0] IND_LIM   = 2'h2;
  localparam logic [1:0] IND_STOP  = 2'h3;
  typedef enum logic [1:0] {ST_STRAP, ST_IDLE, ST_RUN, ST_TRIP} mstate_t;
endpackage
`default_nettype wire

// *** cmd_filter.sv ***
// Two-stage synchroniser and stability filter for one command pin
`default_nettype none
`timescale 1ns/1ps
module cmd_filter #(
  parameter int CYC = 200000
) (
  input  wire logic SYS_CLK, // System clock
  input  wire logic RST,     // Synchronous reset
  input  wire logic pin,     // Raw pin level
  output logic      level    // Filtered level
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        out;
    logic [23:0] cnt;
  } flt_t;
  flt_t s, n;

  if (CYC < 2 || CYC > 24'hFFFFFF) begin : g_chk
    $error("cmd_filter: CYC out of range");
  end

  always_comb begin
    n    = s;
    n.s1 = pin;
    n.s2 = s.s1;
    // Short glitches restart the count and never reach the output
    if (s.s2 == s.out) begin
      n.cnt = 24'h000000;
    end else if (s.cnt == 24'(CYC - 1)) begin
      n.out = s.s2;
      n.cnt = 24'h000000;
    end else begin
      n.cnt = s.cnt + 24'h000001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.out;
endmodule // cmd_filter
`default_nettype wire

// *** ramp_gen.sv ***
// Linear ramp of the drive level toward a target
`default_nettype none
`timescale 1ns/1ps
module ramp_gen (
  input  wire logic        SYS_CLK, // System clock
  input  wire logic        RST,     // Synchronous reset
  input  wire logic        clr,     // Drop level to zero at once
  input  wire logic [9:0]  target,  // Wanted level
  input  wire logic [23:0] up_cyc,  // Cycles per rising step, 0 = jump
  input  wire logic [23:0] dn_cyc,  // Cycles per falling step, 0 = jump
  output logic      [9:0]  level    // Present level
);
  typedef struct packed {
    logic [9:0]  lvl;
    logic [23:0] cnt;
  } ramp_t;
  ramp_t s, n;
  logic [23:0] per;

  always_comb begin
    n   = s;
    per = (s.lvl < target) ? up_cyc : dn_cyc;
    if (clr) begin
      n.lvl = 10'h000;
      n.cnt = 24'h000000;
    end else if (s.lvl == target) begin
      n.cnt = 24'h000000;
    end else if (per == 24'h000000) begin
      n.lvl = target;
    end else if (s.cnt >= per - 24'h000001) begin
      n.cnt = 24'h000000;
      n.lvl = (s.lvl < target) ? s.lvl + 10'h001 : s.lvl - 10'h001;
    end else begin
      n.cnt = s.cnt + 24'h000001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.lvl;
endmodule // ramp_gen
`default_nettype wire

// *** bldc_ctrl.sv ***
// Control logic of a hall-sensor brushless DC motor drive
//
// Local design decisions: the address map and strobed register access.
`default_nettype none
`timescale 1ns/1ps
// Summary of operation
// - Mode 0 runs open loop, mode 1 closed loop; open loop after reset.
// - Open loop drive level follows the speed command proportionally.
// - Closed loop holds hall-measured speed at command, until current limit.
// - Speed range code 1..18 means full scale in thousands rpm; default 6.
// - Dynamic 1..5, default 3; larger means slower speed response.
// - Scale 0 maps command to 0-10 V span, 1 to 0-5 V.
// - Load compensation 0..50 adds low-speed torque, open loop only.
// - Start ramp code 0..8 selects 0 to 1.5 s, default 4.
// - Stop ramp uses the same nine codes, default 4.
// - Start and stop ramps act in both control modes.
// - Current limit 0..60 in 0.1 A, default 15, caps motor current.
// - Trip delay 0 only limits; 1..200 ms sets delay, default 40.
// - Current over limit for the whole delay shuts the drive down.
// - Indication selects none, trip, limit active or stopped; default trip.
// - Trip status reads 0 none, 1 forward trip, 2 reverse trip.
// - Current monitor reads 0..30 in 0.1 A steps.
// - Run command starts the motor forward.
// - Reverse command starts reverse, or turns a forward-running motor.
// - Disable lets the motor coast; release restarts through start ramp.
// - Command pins respond within about 2 ms; shorter pulses are filtered.
// - Run and reverse both held at power-up clear the access code.
module bldc_ctrl #(
  parameter int          DEB_CYC    = bldc_pkg::DEB_CYC,
  parameter int          MS_CYC     = bldc_pkg::MS_CYC,
  parameter int          PWM_CYC    = bldc_pkg::PWM_CYC,
  parameter int          WIN_MS     = bldc_pkg::WIN_MS,
  parameter int          POLE_PAIRS = 2,
  // Arbitrary value standing in for the stored access code
  parameter logic [15:0] ACC_INIT   = 16'h5A5A
) (
  input  wire logic        SYS_CLK,   // 100 MHz clock
  input  wire logic        RST,       // Synchronous reset, high
  input  wire logic [5:0]  ADDR,      // Register byte address
  input  wire logic [15:0] WDATA,     // Write data
  input  wire logic        WR,        // Write strobe
  input  wire logic        RD,        // Read strobe
  output logic      [15:0] RDATA,     // Read data, cycle after RD
  input  wire logic        RUN_IN,    // Run forward pin
  input  wire logic        REV_IN,    // Reverse pin
  input  wire logic        ENABLE_IN, // High = operate, low = coast
  input  wire logic [2:0]  HALL_IN,   // Hall sensor pins
  input  wire logic [9:0]  SPEED_ADC, // Speed input, full scale 10 V
  input  wire logic [7:0]  CUR_ADC,   // Motor current, 0.1 A units
  output logic      [2:0]  PHASE_HI,  // High-side gate drives
  output logic      [2:0]  PHASE_LO,  // Low-side gate drives
  output logic             IND_OUT,   // Indication output
  output logic             FAULT_LED  // Overcurrent or trip lamp
);
  // ==========================================================
  // State
  typedef struct packed {
    bldc_pkg::mstate_t st;
    logic        dir;
    logic [2:0]  h1, h2, h3;
    logic        mode, scale;
    logic [4:0]  rng;
    logic [2:0]  dyn;
    logic [5:0]  lc, ilim;
    logic [3:0]  sramp, pramp;
    logic [7:0]  tdly, ovr_ms;
    logic [1:0]  ind, trip;
    logic [15:0] acc, rdata;
    logic [9:0]  cmd, integ, edges, meas;
    logic [4:0]  cur_mon;
    logic [15:0] pwm_cnt;
    logic [23:0] ms_cnt, strap;
    logic [7:0]  win;
    logic [2:0]  hi, lo;
    logic        ind_o, led;
  } regs_t;
  regs_t s, n;

  if (POLE_PAIRS < 1 || POLE_PAIRS > 16 || WIN_MS < 10 || WIN_MS > 255
      || MS_CYC < 1024 || MS_CYC > 24'hFFFFFF || PWM_CYC < 2
      || PWM_CYC > 16'hFFFF || DEB_CYC > 24'h7FFFFF) begin : g_chk
    $error("bldc_ctrl: parameter out of range");
  end

  localparam logic [23:0] STEP_MUL  = 24'(MS_CYC / 1024);
  localparam logic [23:0] STRAP_CYC = 24'(2 * DEB_CYC + 2);
  localparam logic [15:0] FS_MUL    = 16'(WIN_MS * POLE_PAIRS / 10);

  // ==========================================================
  // Command pins
  logic [2:0] pins, flt;
  logic       run_f, rev_f, en_f;
  assign pins = {ENABLE_IN, REV_IN, RUN_IN};
  for (genvar i = 0; i < 3; i++) begin : g_flt
    cmd_filter #(.CYC(DEB_CYC)) u_flt (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .pin     (pins[i]),
      .level   (flt[i])
    );
  end
  assign run_f = flt[0];
  assign rev_f = flt[1];
  assign en_f  = flt[2];

  // ==========================================================
  // Ramp
  logic [9:0]  level, tgt;
  logic        ramp_clr;
  logic [23:0] up_cyc, dn_cyc;
  assign up_cyc = 24'(bldc_pkg::RAMP_MS[s.sramp] * STEP_MUL);
  assign dn_cyc = 24'(bldc_pkg::RAMP_MS[s.pramp] * STEP_MUL);

  ramp_gen u_ramp (
    .SYS_CLK (SYS_CLK),
    .RST     (RST),
    .clr     (ramp_clr),
    .target  (tgt),
    .up_cyc  (up_cyc),
    .dn_cyc  (dn_cyc),
    .level   (level)
  );

  // Six-step table; reverse swaps the high and low sides
  function automatic logic [5:0] commute(input logic [2:0] h,
                                         input logic d);
    logic [5:0] v;
    v = 6'h00;
    case (h)
      3'b001: v = {3'b001, 3'b010};
      3'b011: v = {3'b001, 3'b100};
      3'b010: v = {3'b010, 3'b100};
      3'b110: v = {3'b010, 3'b001};
      3'b100: v = {3'b100, 3'b001};
      3'b101: v = {3'b100, 3'b010};
      default: v = 6'h00;
    endcase
    return d ? {v[2:0], v[5:3]} : v;
  endfunction

  // ==========================================================
  // Next state
  logic        run_req, over, ms_tick, trip_hit, drive_on, stopped;
  logic [10:0] dbl;
  logic [17:0] boost;
  logic [10:0] ol_duty;
  logic [9:0]  duty;
  logic [15:0] fs;
  logic [25:0] tgt_edges;
  logic [25:0] thr;
  logic [5:0]  cmt;
  int          err, step, nxt;

  always_comb begin
    n = s;
    err = 0;
    step = 0;
    nxt = 0;
    n.h1 = HALL_IN;
    n.h2 = s.h1;
    n.h3 = s.h2;
    run_req = run_f | rev_f;
    // Register writes; out-of-range values are ignored, but mode, scale and indication take the low data bits
    if (WR) begin
      if (ADDR == bldc_pkg::A_MODE) begin
        n.mode = WDATA[0];
      end else if (ADDR == bldc_pkg::A_RANGE) begin
        if (WDATA >= 16'(bldc_pkg::RANGE_MIN)
            && WDATA <= 16'(bldc_pkg::RANGE_MAX)) n.rng = WDATA[4:0];
      end else if (ADDR == bldc_pkg::A_DYN) begin
        if (WDATA >= 16'(bldc_pkg::DYN_MIN)
            && WDATA <= 16'(bldc_pkg::DYN_MAX)) n.dyn = WDATA[2:0];
      end else if (ADDR == bldc_pkg::A_SCALE) begin
        n.scale = WDATA[0];
      end else if (ADDR == bldc_pkg::A_LCOMP) begin
        if (WDATA <= 16'(bldc_pkg::LC_MAX)) n.lc = WDATA[5:0];
      end else if (ADDR == bldc_pkg::A_SRAMP) begin
        if (WDATA <= 16'(bldc_pkg::RAMP_MAX)) n.sramp = WDATA[3:0];
      end else if (ADDR == bldc_pkg::A_PRAMP) begin
        if (WDATA <= 16'(bldc_pkg::RAMP_MAX)) n.pramp = WDATA[3:0];
      end else if (ADDR == bldc_pkg::A_ILIM) begin
        if (WDATA <= 16'(bldc_pkg::ILIM_MAX)) n.ilim = WDATA[5:0];
      end else if (ADDR == bldc_pkg::A_TDLY) begin
        if (WDATA <= 16'(bldc_pkg::TDLY_MAX)) n.tdly = WDATA[7:0];
      end else if (ADDR == bldc_pkg::A_IND) begin
        n.ind = WDATA[1:0];
      end else if (ADDR == bldc_pkg::A_ACC) begin
        n.acc = WDATA;
      end
    end
    // Reads; unmapped addresses return zero
    n.rdata = 16'h0000;
    if (RD) begin
      if (ADDR == bldc_pkg::A_MODE) n.rdata = {15'h0000, s.mode};
      else if (ADDR == bldc_pkg::A_RANGE) n.rdata = {11'h000, s.rng};
      else if (ADDR == bldc_pkg::A_DYN) n.rdata = {13'h0000, s.dyn};
      else if (ADDR == bldc_pkg::A_SCALE) n.rdata = {15'h0000, s.scale};
      else if (ADDR == bldc_pkg::A_LCOMP) n.rdata = {10'h000, s.lc};
      else if (ADDR == bldc_pkg::A_SRAMP) n.rdata = {12'h000, s.sramp};
      else if (ADDR == bldc_pkg::A_PRAMP) n.rdata = {12'h000, s.pramp};
      else if (ADDR == bldc_pkg::A_ILIM) n.rdata = {10'h000, s.ilim};
      else if (ADDR == bldc_pkg::A_TDLY) n.rdata = {8'h00, s.tdly};
      else if (ADDR == bldc_pkg::A_IND) n.rdata = {14'h0000, s.ind};
      else if (ADDR == bldc_pkg::A_TRIP) n.rdata = {14'h0000, s.trip};
      else if (ADDR == bldc_pkg::A_SPEED) n.rdata = {6'h00, s.cmd};
      else if (ADDR == bldc_pkg::A_CUR) n.rdata = {11'h000, s.cur_mon};
      else if (ADDR == bldc_pkg::A_ACC) n.rdata = s.acc;
      else if (ADDR == bldc_pkg::A_STAT)
        n.rdata = {2'h0, level[9:2], s.dir, run_req, en_f, 1'b0, 2'(s.st)};
    end
    // Speed command scaling; 0-5 V span saturates above half scale
    dbl = s.scale ? {SPEED_ADC, 1'b0} : {1'b0, SPEED_ADC};
    n.cmd = dbl[10] ? 10'h3FF : dbl[9:0];
    n.cur_mon = (CUR_ADC > 8'(bldc_pkg::CUR_MAX)) ? bldc_pkg::CUR_MAX
                                                   : CUR_ADC[4:0];
    over = CUR_ADC > {2'b00, s.ilim};
    // Millisecond time base and over-limit duration
    ms_tick = (s.ms_cnt == 24'(MS_CYC - 1));
    n.ms_cnt = ms_tick ? 24'h000000 : s.ms_cnt + 24'h000001;
    if (!over) begin
      n.ovr_ms = 8'h00;
    end else if (ms_tick && s.ovr_ms != 8'hFF) begin
      n.ovr_ms = s.ovr_ms + 8'h01;
    end
    trip_hit = (s.tdly != 8'h00) && over && (s.ovr_ms >= s.tdly);
    // Sequencing
    case (s.st)
      bldc_pkg::ST_STRAP: begin
        n.strap = s.strap + 24'h000001;
        if (s.strap == STRAP_CYC) begin
          if (run_f && rev_f) n.acc = 16'h0000;
          n.st = bldc_pkg::ST_IDLE;
        end
      end
      bldc_pkg::ST_IDLE: begin
        if (run_req && en_f) begin
          n.trip = bldc_pkg::TRIP_NONE;
          n.dir  = rev_f;
          n.st   = bldc_pkg::ST_RUN;
        end
      end
      bldc_pkg::ST_RUN: begin
        if (trip_hit) begin
          n.trip = s.dir ? bldc_pkg::TRIP_REV : bldc_pkg::TRIP_FWD;
          n.st   = bldc_pkg::ST_TRIP;
        end else if (!run_req && level == 10'h000) begin
          n.st = bldc_pkg::ST_IDLE;
        end else if (run_req && rev_f != s.dir && level == 10'h000) begin
          n.dir = rev_f;
        end
      end
      bldc_pkg::ST_TRIP: begin
        if (!run_req) n.st = bldc_pkg::ST_IDLE;
      end
      default: n.st = bldc_pkg::ST_IDLE;
    endcase
    // A direction change first ramps down to zero
    tgt = (s.st == bldc_pkg::ST_RUN && run_req && rev_f == s.dir)
          ? s.cmd : 10'h000;
    ramp_clr = !en_f || s.st != bldc_pkg::ST_RUN;
    // Closed loop: hall edges counted over a fixed window
    fs = 16'(s.rng) * FS_MUL;
    tgt_edges = (26'(level) * 26'(fs)) >> 10;
    if (ms_tick) n.win = (s.win == 8'(WIN_MS - 1)) ? 8'h00 : s.win + 8'h01;
    if (ms_tick && s.win == 8'(WIN_MS - 1)) begin
      n.meas  = s.edges;
      n.edges = 10'h000;
      err  = int'(tgt_edges[15:0]) - int'(s.edges);
      step = (err * 16) >>> s.dyn;
      nxt  = int'(s.integ) + step;
      n.integ = (nxt < 0) ? 10'h000 : (nxt > 1023) ? 10'h3FF : 10'(nxt);
    end else if (s.h2 != s.h3 && s.edges != 10'h3FF) begin
      n.edges = s.edges + 10'h001;
    end
    if (level == 10'h000) n.integ = 10'h000;
    // Open loop: level plus load boost that fades with speed
    boost = (18'(s.lc) * 18'(10'h3FF - level)) >> 6;
    ol_duty = (level == 10'h000) ? 11'h000
              : 11'(level) + 11'(boost[10:0]);
    duty = s.mode ? s.integ : (ol_duty[10] ? 10'h3FF : ol_duty[9:0]);
    // PWM and commutation
    n.pwm_cnt = (s.pwm_cnt == 16'(PWM_CYC - 1)) ? 16'h0000
                : s.pwm_cnt + 16'h0001;
    thr = (26'(duty) * 26'(PWM_CYC)) >> 10;
    cmt = commute(s.h2, s.dir);
    drive_on = s.st == bldc_pkg::ST_RUN && en_f && level != 10'h000;
    // Limiting: high side chopped off while current is above limit
    n.hi = (drive_on && !over && 26'(s.pwm_cnt) < thr)
           ? cmt[5:3] : 3'b000;
    n.lo = drive_on ? cmt[2:0] : 3'b000;
    stopped = !drive_on;
    case (s.ind)
      bldc_pkg::IND_NONE: n.ind_o = 1'b0;
      bldc_pkg::IND_TRIP: n.ind_o = s.st == bldc_pkg::ST_TRIP;
      bldc_pkg::IND_LIM:  n.ind_o = over;
      default:            n.ind_o = stopped;
    endcase
    n.led = over || s.st == bldc_pkg::ST_TRIP;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s       <= '0;
      s.st    <= bldc_pkg::ST_STRAP;
      s.mode  <= bldc_pkg::MODE_RST;
      s.rng   <= bldc_pkg::RANGE_RST;
      s.dyn   <= bldc_pkg::DYN_RST;
      s.scale <= bldc_pkg::SCALE_RST;
      s.lc    <= bldc_pkg::LC_RST;
      s.sramp <= bldc_pkg::RAMP_RST;
      s.pramp <= bldc_pkg::RAMP_RST;
      s.ilim  <= bldc_pkg::ILIM_RST;
      s.tdly  <= bldc_pkg::TDLY_RST;
      s.ind   <= bldc_pkg::IND_RST;
      s.acc   <= ACC_INIT;
    end else begin
      s <= n;
    end
  end

  assign RDATA     = s.rdata;
  assign PHASE_HI  = s.hi;
  assign PHASE_LO  = s.lo;
  assign IND_OUT   = s.ind_o;
  assign FAULT_LED = s.led;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_trip_fire;
    s.st == bldc_pkg::ST_RUN && trip_hit;
  endsequence
  sequence s_trip_hold;
    s.st == bldc_pkg::ST_TRIP ##1 (PHASE_HI == 3'b000 && PHASE_LO == 3'b000);
  endsequence

  a_trip_shutdown: assert property (
    s_trip_fire |=> s_trip_hold)
    else $error("trip did not shut the drive down");
  a_trip_not_early: assert property (
    $rose(s.st == bldc_pkg::ST_TRIP) |->
      $past(s.ovr_ms) >= $past(s.tdly) && $past(s.tdly) != 8'h00)
    else $error("trip before the delay or while disabled");
  a_trip_status: assert property (
    $rose(s.st == bldc_pkg::ST_TRIP) |->
      s.trip == ($past(s.dir) ? bldc_pkg::TRIP_REV : bldc_pkg::TRIP_FWD))
    else $error("trip status does not match direction");
  a_trip_latched: assert property (
    s.st == bldc_pkg::ST_TRIP && run_req |=>
      s.st == bldc_pkg::ST_TRIP && s.trip != bldc_pkg::TRIP_NONE)
    else $error("trip left while a command still held");
  a_disable_coast: assert property (
    !en_f |=> PHASE_HI == 3'b000 && PHASE_LO == 3'b000 && level == 10'h000)
    else $error("drive not released while disabled");
  a_cur_mon_sat: assert property (
    CUR_ADC > 8'h1E |=> s.cur_mon == bldc_pkg::CUR_MAX)
    else $error("current monitor not held at 30");
  a_read_trip: assert property (
    RD && ADDR == bldc_pkg::A_TRIP |=> RDATA == {14'h0000, $past(s.trip)})
    else $error("trip status read mismatch");
  a_limit_chop: assert property (
    over |=> PHASE_HI == 3'b000)
    else $error("high side on above current limit");
  a_ind_limit: assert property (
    s.ind == bldc_pkg::IND_LIM && over |=> IND_OUT)
    else $error("limit indication missing");
  a_range_guard: assert property (
    WR && ADDR == bldc_pkg::A_RANGE && WDATA > 16'h0012 |=> $stable(s.rng))
    else $error("illegal range code accepted");
endmodule // bldc_ctrl
`default_nettype wire

// *** hall_motor.sv ***
// Behavioural brushless motor whose hall pattern steps while it is driven
`default_nettype none
`timescale 1ns/1ps
module hall_motor #(
  parameter int STEP_CYC = 40
) (
  input  wire logic       SYS_CLK,  // System clock
  input  wire logic [2:0] PHASE_HI, // High-side drives
  input  wire logic [2:0] PHASE_LO, // Low-side drives
  output logic      [2:0] HALL_IN   // Hall sensor levels
);
  logic [2:0] pos_q = 3'h0;
  int         cnt_q = 0;
  // ==========================================================
  // Rotor only turns while a high side and a low side are both driven, so coasting stalls
  always @(posedge SYS_CLK) begin
    if ((|PHASE_HI) && (|PHASE_LO)) begin
      cnt_q <= (cnt_q == STEP_CYC) ? 0 : cnt_q + 1;
      if (cnt_q == STEP_CYC) pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
    end
  end
  always_comb begin
    case (pos_q)
      3'h0: HALL_IN = 3'h1;
      3'h1: HALL_IN = 3'h3;
      3'h2: HALL_IN = 3'h2;
      3'h3: HALL_IN = 3'h6;
      3'h4: HALL_IN = 3'h4;
      default: HALL_IN = 3'h5;
    endcase
  end
endmodule // hall_motor
`default_nettype wire

// *** bldc_ctrl_tb.sv ***
// Self-checking testbench of the motor drive control
`default_nettype none
`timescale 1ns/1ps
module bldc_ctrl_tb;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic run_in = 1'b0, rev_in = 1'b0, enable_in = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [9:0] speed_adc = 10'h200;
  logic [7:0] cur_adc = 8'h00;
  logic [2:0] hall_in, phase_hi, phase_lo;
  logic ind_out, fault_led;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  bldc_ctrl #(.DEB_CYC(8), .MS_CYC(1024), .PWM_CYC(16), .WIN_MS(10))
  bldc_ctrl_inst (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .RUN_IN(run_in), .REV_IN(rev_in),
    .ENABLE_IN(enable_in), .HALL_IN(hall_in), .SPEED_ADC(speed_adc),
    .CUR_ADC(cur_adc), .PHASE_HI(phase_hi), .PHASE_LO(phase_lo),
    .IND_OUT(ind_out), .FAULT_LED(fault_led));
  hall_motor hall_motor_inst (.SYS_CLK(sys_clk), .PHASE_HI(phase_hi),
    .PHASE_LO(phase_lo), .HALL_IN(hall_in));
  // ==========================================================
  // Bus tasks and comparison
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge sys_clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a);
    @(posedge sys_clk) begin rd <= 1'b1; addr <= a; end
    @(posedge sys_clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [15:0] e);
    rreg(a);
    chk(nm, e, v);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rchk("mode", bldc_pkg::A_MODE, {15'h0, bldc_pkg::MODE_RST});
    rchk("range", bldc_pkg::A_RANGE, {11'h0, bldc_pkg::RANGE_RST});
    rchk("dyn", bldc_pkg::A_DYN, {13'h0, bldc_pkg::DYN_RST});
    rchk("scale", bldc_pkg::A_SCALE, {15'h0, bldc_pkg::SCALE_RST});
    rchk("lcomp", bldc_pkg::A_LCOMP, {10'h0, bldc_pkg::LC_RST});
    rchk("sramp", bldc_pkg::A_SRAMP, {12'h0, bldc_pkg::RAMP_RST});
    rchk("pramp", bldc_pkg::A_PRAMP, {12'h0, bldc_pkg::RAMP_RST});
    rchk("ilim", bldc_pkg::A_ILIM, {10'h0, bldc_pkg::ILIM_RST});
    rchk("tdly", bldc_pkg::A_TDLY, {8'h0, bldc_pkg::TDLY_RST});
    rchk("ind", bldc_pkg::A_IND, {14'h0, bldc_pkg::IND_RST});
    rchk("trip", bldc_pkg::A_TRIP, {14'h0, bldc_pkg::TRIP_NONE});
    rchk("unmapped", 6'h3C, 16'h0000);
  endtask
  task automatic t_limits;
    wreg(bldc_pkg::A_RANGE, 16'h0013);
    rchk("range oor", bldc_pkg::A_RANGE, {11'h0, bldc_pkg::RANGE_RST});
    wreg(bldc_pkg::A_ILIM, 16'h0014);
    rchk("ilim wr", bldc_pkg::A_ILIM, 16'h0014);
    wreg(bldc_pkg::A_ILIM, 16'h003D);
    rchk("ilim oor", bldc_pkg::A_ILIM, 16'h0014);
    wreg(bldc_pkg::A_MODE, 16'h0001);
    rchk("mode wr", bldc_pkg::A_MODE, 16'h0001);
    wreg(bldc_pkg::A_MODE, 16'h0000);
    wreg(bldc_pkg::A_SCALE, 16'h0001);
    rchk("speed 5v", bldc_pkg::A_SPEED, 16'h03FF);
    wreg(bldc_pkg::A_SCALE, 16'h0000);
    rchk("speed 10v", bldc_pkg::A_SPEED, 16'h0200);
    wreg(bldc_pkg::A_ACC, 16'h1234);
    rchk("acc wr", bldc_pkg::A_ACC, 16'h1234);
  endtask
  task automatic t_cur;
    cur_adc <= 8'h2D;
    wreg(bldc_pkg::A_IND, 16'h0002);
    rchk("cur sat", bldc_pkg::A_CUR, {11'h0, bldc_pkg::CUR_MAX});
    chk("ind lim", 16'h0001, {15'h0, ind_out});
    chk("led over", 16'h0001, {15'h0, fault_led});
    cur_adc <= 8'h0C;
    rchk("cur", bldc_pkg::A_CUR, 16'h000C);
    chk("ind clear", 16'h0000, {15'h0, ind_out});
    wreg(bldc_pkg::A_IND, 16'h0003);
    rchk("ind wr", bldc_pkg::A_IND, 16'h0003);
    chk("ind stop", 16'h0001, {15'h0, ind_out});
  endtask
  task automatic t_run;
    wreg(bldc_pkg::A_SRAMP, 16'h0000);
    wreg(bldc_pkg::A_PRAMP, 16'h0000);
    @(posedge sys_clk) run_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    run_in <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rreg(bldc_pkg::A_STAT);
    chk("glitch", 16'h0001, v & 16'h0003);
    run_in <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rreg(bldc_pkg::A_STAT);
    chk("run state", 16'h0002, v & 16'h0023);
    chk("lo on", 16'h0001, {15'h0, |phase_lo});
    chk("ind run", 16'h0000, {15'h0, ind_out});
    enable_in <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 chk("coast", 16'h0000, {10'h0, phase_hi, phase_lo});
    enable_in <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk("restart", 16'h0001, {15'h0, |phase_lo});
    rev_in <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rreg(bldc_pkg::A_STAT);
    chk("rev state", 16'h0022, v & 16'h0023);
  endtask
  task automatic t_trip;
    wreg(bldc_pkg::A_IND, 16'h0001);
    wreg(bldc_pkg::A_ILIM, 16'h000A);
    wreg(bldc_pkg::A_TDLY, 16'h0001);
    @(posedge sys_clk) cur_adc <= 8'h32;
    repeat (2300) @(posedge sys_clk);
    rchk("trip", bldc_pkg::A_TRIP, {14'h0, bldc_pkg::TRIP_REV});
    chk("fault led", 16'h0001, {15'h0, fault_led});
    chk("ind trip", 16'h0001, {15'h0, ind_out});
    @(posedge sys_clk) cur_adc <= 8'h00;
    repeat (50) @(posedge sys_clk);
    rreg(bldc_pkg::A_STAT);
    chk("trip held", 16'h0003, v & 16'h0003);
    chk("drive off", 16'h0000, {10'h0, phase_hi, phase_lo});
    run_in <= 1'b0;
    rev_in <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rreg(bldc_pkg::A_STAT);
    chk("released", 16'h0001, v & 16'h0003);
    rchk("trip kept", bldc_pkg::A_TRIP, {14'h0, bldc_pkg::TRIP_REV});
    run_in <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rchk("trip clr", bldc_pkg::A_TRIP, {14'h0, bldc_pkg::TRIP_NONE});
  endtask
  // Second reset with both commands held clears the access code
  task automatic t_strap;
    rev_in <= 1'b1;
    @(posedge sys_clk) rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rchk("acc clr", bldc_pkg::A_ACC, 16'h0000);
    rchk("ilim rst", bldc_pkg::A_ILIM, {10'h0, bldc_pkg::ILIM_RST});
  endtask
  // ==========================================================
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    enable_in <= 1'b1;
    t_regs();
    t_limits();
    t_cur();
    t_run();
    t_trip();
    t_strap();
    results();
  end
endmodule // bldc_ctrl_tb
`default_nettype wire
